// ===== lsdc_regs.svh
// Register map, field positions, reset values and timing counts of the low-side driver configuration block.
// Assumes a word-index register map placed on 32-bit AHB-Lite words, one register per word.
`ifndef LSDC_REGS_SVH
`define LSDC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LSDC_IDX_GATE_DATA 8'h00
`define LSDC_IDX_DRV_CFG 8'h01
`define LSDC_IDX_OC_TRIM 8'h02
`define LSDC_IDX_OL_STATUS 8'h05
`define LSDC_IDX_MODE 8'h08

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LSDC_CFG_EN_LSB 0
`define LSDC_CFG_OLE_LSB 2
`define LSDC_TRIM_LSB 0
`define LSDC_CFG_RESET 4'h0
`define LSDC_GATE_RESET 2'h0
`define LSDC_TRIM_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Clock cycles that software waits after powering a driver before it turns the gate on.
// The real figure depends on the analog stage, so this is a plain default to be tuned.
`define LSDC_SETTLE_CYCLES 16

`endif

// ===== lsdc_pkg.sv
// Types shared by the low-side driver configuration files.
// Assumes the register header is included where offsets are needed.
package lsdc_pkg;
   typedef enum logic [1:0] {LSDC_LD_IDLE, LSDC_LD_REQ, LSDC_LD_DONE} lsdc_load_state_t;
endpackage : lsdc_pkg

// ===== lsdc_drv_ctl.sv
// One low-side driver control slice: power, gate and open-load detector gating.
// Assumes the analog stage samples these levels directly.
`timescale 1ns/1ps
module lsdc_drv_ctl
   import lsdc_pkg::*;
(
   input wire logic enable_i,
   input wire logic ol_enable_i,
   input wire logic gate_src_i,
   input wire logic ol_raw_i,
   output logic gate_on_o,
   output logic ol_active_o,
   output logic ol_status_o
);
   // A disabled driver is in shutdown, so gate and detector are both held off.
   assign gate_on_o = enable_i & gate_src_i;
   // The detector only measures while the gate is off, as current must not flow through the driver.
   assign ol_active_o = enable_i & ~gate_src_i & ol_enable_i;
   // Status is only meaningful while the detector runs; otherwise it reads zero.
   assign ol_status_o = ol_active_o & ol_raw_i;
endmodule : lsdc_drv_ctl

// ===== lsdc_top.sv
// Top of the low-side driver configuration block: AHB-Lite slave, config, gate data and trim registers.
// Assumes a single AHB-Lite master, a flash loader handshake for the trim value, and analog driver stages.
`timescale 1ns/1ps
`include "lsdc_regs.svh"

// Overview of operation
// - Configuration bits 3-2 enable open-load detection per driver, one bit each.
// - A driver's open-load detector runs only when enabled, gate undriven and detection enabled.
// - Configuration bits 1-0 power each driver, where 1 enables it.
// - A driver whose enable bit is 0 is held in shutdown with gate and detector off.
// - The trim register reads at any time and takes writes only in special mode.
// - After system reset the trim register is loaded from nonvolatile memory.
// - Trim bits 1-0 set the over-current threshold shared by both drivers.
// - The trim value is decoded one-hot: 0 to 0001, 1 to 0010, 2 to 0100, 3 to 1000.
// - A gate data bit of 1 turns the gate on and 0 turns it off.
// - Each driver reports open-load status, valid only while its detector is active.
module lsdc_top
   import lsdc_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic SYS_RST_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic SPECIAL_MODE_I,
   input wire logic [7:0] FLASH_TRIM_I,
   input wire logic FLASH_VALID_I,
   output logic FLASH_REQ_O,
   input wire logic [1:0] OPEN_LOAD_RAW_I,
   output logic [1:0] DRIVER_POWER_ENABLE_O,
   output logic [1:0] GATE_ON_O,
   output logic [1:0] OPEN_LOAD_ACTIVE_O,
   output logic [3:0] OC_THRESHOLD_SEL_O
);

   // ----------------------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------------------
   logic wr_pend_ff;
   logic [7:0] wr_idx_ff;
   logic [3:0] cfg_ff;
   logic [1:0] gate_data_ff;
   logic [7:0] trim_ff;
   logic special_ff;
   logic [2:0] mode_sync_ff;
   logic [2:0] ol_sync_ff [0:1];
   logic [1:0] ol_raw_stable;
   logic [1:0] ol_status;
   lsdc_load_state_t load_state_ff;
   logic addr_ok;
   logic [7:0] rd_idx;
   logic [31:0] nxt_rdata;

   // Only aligned word accesses decode; others still get OKAY and read zero.
   assign addr_ok = HSEL_I & HREADY_I & HTRANS_I[1] & (HADDR_I[1:0] == 2'h0) & (HSIZE_I == 3'h2);
   assign rd_idx = HADDR_I[9:2];
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;

   // Writes are held to the data phase, since hwdata arrives one cycle after the address.
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok & HWRITE_I;
         wr_idx_ff <= rd_idx;
      end
   end

   // ----------------------------------------------------------------------------
   // Configuration and gate data registers
   // ----------------------------------------------------------------------------
   // Both drivers come out of reset powered down with detection off.
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         cfg_ff <= `LSDC_CFG_RESET;
      end else if (wr_pend_ff && wr_idx_ff == `LSDC_IDX_DRV_CFG) begin
         cfg_ff <= HWDATA_I[3:0];
      end
   end

   // Gate data is the control source for both gates.
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         gate_data_ff <= `LSDC_GATE_RESET;
      end else if (wr_pend_ff && wr_idx_ff == `LSDC_IDX_GATE_DATA) begin
         gate_data_ff <= HWDATA_I[1:0];
      end
   end

   // Special mode is a pin from outside this clock domain: three stages, counted once the last two agree.
   // A glitch on the strap therefore cannot open the trim register for a single stray cycle.
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         mode_sync_ff <= 3'h0;
         special_ff <= 1'b0;
      end else begin
         mode_sync_ff <= {mode_sync_ff[1:0], SPECIAL_MODE_I};
         if (mode_sync_ff[1] == mode_sync_ff[2]) begin
            special_ff <= mode_sync_ff[2];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Trim register with flash reload
   // ----------------------------------------------------------------------------
   // After reset release the trim is requested from flash; a flash load wins over a bus write in the same cycle.
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         load_state_ff <= LSDC_LD_IDLE;
      end else begin
         case (load_state_ff)
            LSDC_LD_IDLE: load_state_ff <= LSDC_LD_REQ;
            LSDC_LD_REQ: if (FLASH_VALID_I) load_state_ff <= LSDC_LD_DONE;
            LSDC_LD_DONE: load_state_ff <= LSDC_LD_DONE;
            default: load_state_ff <= LSDC_LD_IDLE;
         endcase
      end
   end
   assign FLASH_REQ_O = (load_state_ff == LSDC_LD_REQ);

   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         trim_ff <= `LSDC_TRIM_RESET;
      end else if (load_state_ff == LSDC_LD_REQ && FLASH_VALID_I) begin
         trim_ff <= FLASH_TRIM_I;
      end else if (wr_pend_ff && wr_idx_ff == `LSDC_IDX_OC_TRIM && special_ff) begin
         trim_ff <= HWDATA_I[7:0];
      end
   end

   // One-hot threshold select shared by both over-current comparators.
   always_comb begin
      OC_THRESHOLD_SEL_O = 4'h0;
      OC_THRESHOLD_SEL_O[trim_ff[`LSDC_TRIM_LSB +: 2]] = 1'b1;
   end

   // ----------------------------------------------------------------------------
   // Driver slices
   // ----------------------------------------------------------------------------
   // Open-load comparator outputs are analog and asynchronous: three stages, two must agree.
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_drv
         logic stable_ff;
         always_ff @(posedge CLOCK_I) begin
            if (SYS_RST_I) begin
               ol_sync_ff[g] <= 3'h0;
               stable_ff <= 1'b0;
            end else begin
               ol_sync_ff[g] <= {ol_sync_ff[g][1:0], OPEN_LOAD_RAW_I[g]};
               if (ol_sync_ff[g][1] == ol_sync_ff[g][2]) begin
                  stable_ff <= ol_sync_ff[g][2];
               end
            end
         end
         assign ol_raw_stable[g] = stable_ff;
         lsdc_drv_ctl u_drv (
            .enable_i(cfg_ff[`LSDC_CFG_EN_LSB + g]),
            .ol_enable_i(cfg_ff[`LSDC_CFG_OLE_LSB + g]),
            .gate_src_i(gate_data_ff[g]),
            .ol_raw_i(ol_raw_stable[g]),
            .gate_on_o(GATE_ON_O[g]),
            .ol_active_o(OPEN_LOAD_ACTIVE_O[g]),
            .ol_status_o(ol_status[g])
         );
      end
   endgenerate
   assign DRIVER_POWER_ENABLE_O = cfg_ff[`LSDC_CFG_EN_LSB +: 2];

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------
   // Read data is registered in the address phase so it stands through the data phase.
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (addr_ok && !HWRITE_I) begin
         case (rd_idx)
            `LSDC_IDX_GATE_DATA: nxt_rdata = {30'h0, gate_data_ff};
            `LSDC_IDX_DRV_CFG: nxt_rdata = {28'h0, cfg_ff};
            `LSDC_IDX_OC_TRIM: nxt_rdata = {24'h0, trim_ff};
            `LSDC_IDX_OL_STATUS: nxt_rdata = {30'h0, ol_status};
            `LSDC_IDX_MODE: nxt_rdata = {31'h0, special_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else begin
         HRDATA_O <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   sequence s_cfg_write;
      wr_pend_ff && wr_idx_ff == `LSDC_IDX_DRV_CFG;
   endsequence

   property p_cfg_store;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      s_cfg_write |=> cfg_ff == $past(HWDATA_I[3:0]);
   endproperty
   a_cfg_store: assert property (p_cfg_store) else $error("Config write not stored.");

   property p_ol_active;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      OPEN_LOAD_ACTIVE_O == (cfg_ff[1:0] & ~gate_data_ff & cfg_ff[3:2]);
   endproperty
   a_ol_active: assert property (p_ol_active) else $error("Detector gating wrong.");

   property p_power;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      s_cfg_write |=> DRIVER_POWER_ENABLE_O == $past(HWDATA_I[1:0]);
   endproperty
   a_power: assert property (p_power) else $error("Power enable not following write.");

   property p_shutdown;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      (GATE_ON_O & ~DRIVER_POWER_ENABLE_O) == 2'h0 && (OPEN_LOAD_ACTIVE_O & ~DRIVER_POWER_ENABLE_O) == 2'h0;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("Disabled driver active.");

   property p_trim_protect;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      (wr_pend_ff && wr_idx_ff == `LSDC_IDX_OC_TRIM && !special_ff && load_state_ff == LSDC_LD_DONE)
         |=> $stable(trim_ff);
   endproperty
   a_trim_protect: assert property (p_trim_protect) else $error("Trim written in normal mode.");

   property p_flash_load;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      (load_state_ff == LSDC_LD_REQ && FLASH_VALID_I) |=> trim_ff == $past(FLASH_TRIM_I);
   endproperty
   a_flash_load: assert property (p_flash_load) else $error("Trim not loaded from flash.");

   property p_onehot;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      OC_THRESHOLD_SEL_O == (4'h1 << trim_ff[1:0]);
   endproperty
   a_onehot: assert property (p_onehot) else $error("Threshold select not one-hot of trim.");

   property p_reset_cfg;
      @(posedge CLOCK_I) SYS_RST_I |=> cfg_ff == 4'h0 && DRIVER_POWER_ENABLE_O == 2'h0;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("Config not cleared by reset.");

endmodule : lsdc_top

// ===== lsdc_tb_top.sv
// Self-checking testbench for the low-side driver configuration block.
// Assumes the DUT is the only AHB-Lite slave, so its hreadyout feeds back as the bus hready.
`timescale 1ns/1ps
`include "lsdc_regs.svh"
module lsdc_tb_top;
   // ----------------------------------------------------------------------------
   // Signals and register byte addresses
   // ----------------------------------------------------------------------------
   localparam logic [31:0] A_GATE = 32'(`LSDC_IDX_GATE_DATA) << 2;
   localparam logic [31:0] A_CFG = 32'(`LSDC_IDX_DRV_CFG) << 2;
   localparam logic [31:0] A_TRIM = 32'(`LSDC_IDX_OC_TRIM) << 2;
   localparam logic [31:0] A_STAT = 32'(`LSDC_IDX_OL_STATUS) << 2;
   localparam logic [31:0] A_MODE = 32'(`LSDC_IDX_MODE) << 2;
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hready, hresp, special = 1'b0, fvalid = 1'b0, freq;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_smp = '0;
   logic [1:0] htrans = 2'b00, raw = 2'b00, pwr, gate_on, ola;
   logic [7:0] ftrim = '0, rnd = 8'h18;
   logic [3:0] hot;
   logic rdy_smp = 1'b0;
   int err_total = 0, num_checks = 0;

   lsdc_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .SPECIAL_MODE_I(special), .FLASH_TRIM_I(ftrim),
      .FLASH_VALID_I(fvalid), .FLASH_REQ_O(freq), .OPEN_LOAD_RAW_I(raw), .DRIVER_POWER_ENABLE_O(pwr),
      .GATE_ON_O(gate_on), .OPEN_LOAD_ACTIVE_O(ola), .OC_THRESHOLD_SEL_O(hot));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk = ~clk;
   end

   // Bus answers are captured at the edge itself, so the design's own update at that edge cannot race us.
   always @(posedge clk) begin
      rd_smp <= hrdata;
      rdy_smp <= hready;
   end

   // ----------------------------------------------------------------------------
   // Helpers: random source, expectations, checks and bus cycles
   // ----------------------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic logic [3:0] f_hot(input logic [1:0] t);
      return 4'h1 << t;
   endfunction : f_hot

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Waits for hready at successive edges; the count bounds a hung slave.
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (rdy_smp !== 1'b1 && n < 50);
      if (n >= 50) chk("hready", 1, 0);
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = rd_smp;
      chk("hresp", 0, 32'(hresp));
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, '0, x);
      chk(nm, e, x);
   endtask : rdc

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // Watchdog: the whole sequence needs a few thousand cycles at most.
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("ERROR watchdog expected finish seen timeout");
      wrap_up();
   end

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial begin
      logic [3:0] c;
      logic [1:0] g;
      logic [7:0] t;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("power_rst", 0, 32'(pwr));
      chk("gate_rst", 0, 32'(gate_on));
      chk("ola_rst", 0, 32'(ola));
      chk("hot_rst", 32'(4'b0001), 32'(hot));
      chk("flash_req", 1, 32'(freq));
      rdc("cfg_rst", A_CFG, 0);
      $display("test reset done");
      // Flash delivers a random trim; the register must take it without any bus write.
      rnd = lfsr(rnd);
      @(posedge clk);
      ftrim <= rnd;
      fvalid <= 1'b1;
      @(posedge clk);
      fvalid <= 1'b0;
      @(posedge clk);
      #1;
      chk("flash_req_done", 0, 32'(freq));
      rdc("trim_flash", A_TRIM, 32'(rnd));
      chk("hot_flash", 32'(f_hot(rnd[1:0])), 32'(hot));
      // Normal-mode trim write must leave the flash value in place.
      t = rnd;
      rnd = lfsr(rnd);
      wr(A_TRIM, 32'(~t));
      rdc("trim_normal", A_TRIM, 32'(t));
      rdc("mode_normal", A_MODE, 0);
      $display("test flash done");
      // Special mode: every trim code reaches the shared one-hot select.
      // The mode pin passes a three-stage synchroniser before it counts.
      special <= 1'b1;
      repeat (6) @(posedge clk);
      rdc("mode_special", A_MODE, 1);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         t = {rnd[7:2], 2'(i)};
         wr(A_TRIM, 32'(t));
         rdc("trim_special", A_TRIM, 32'(t));
         #1;
         chk("hot", 32'(f_hot(2'(i))), 32'(hot));
      end
      special <= 1'b0;
      $display("test trim done");
      // Every config code, with gate data (zero for every third code) and open-load inputs (both high for the last) drawn at random.
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         c = 4'(i);
         g = (i % 3 == 0) ? 2'b00 : rnd[1:0];
         raw <= (i == 15) ? 2'b11 : rnd[3:2];
         // Gates go off before power changes, and on only after the settling wait.
         wr(A_GATE, 32'h0);
         wr(A_CFG, 32'(c));
         repeat (`LSDC_SETTLE_CYCLES) @(posedge clk);
         wr(A_GATE, 32'(g));
         repeat (8) @(posedge clk);
         #1;
         chk("power", 32'(c[1:0]), 32'(pwr));
         chk("gate_on", 32'(c[1:0] & g), 32'(gate_on));
         chk("ol_active", 32'(c[1:0] & ~g & c[3:2]), 32'(ola));
         rdc("cfg", A_CFG, 32'(c));
         rdc("gate_data", A_GATE, 32'(g));
         rdc("ol_status", A_STAT, 32'(c[1:0] & ~g & c[3:2] & raw));
      end
      $display("test config done");
      // Unmapped word reads zero and ignores writes.
      wr(32'h0000_000c, 32'hffff_ffff);
      rdc("unmapped", 32'h0000_000c, 0);
      rdc("cfg_kept", A_CFG, 32'(4'hf));
      $display("test unmapped done");
      // A second reset in mid-run clears the config and fetches the trim from flash again.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("power_rst2", 0, 32'(pwr));
      chk("flash_req2", 1, 32'(freq));
      rnd = lfsr(rnd);
      @(posedge clk);
      ftrim <= rnd;
      fvalid <= 1'b1;
      @(posedge clk);
      fvalid <= 1'b0;
      rdc("cfg_rst2", A_CFG, 0);
      rdc("trim_flash2", A_TRIM, 32'(rnd));
      chk("hot_flash2", 32'(f_hot(rnd[1:0])), 32'(hot));
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule : lsdc_tb_top
